// file: pic_pkg.sv
package pic_pkg;
    localparam int unsigned PIC_ADDR_W = 8;
    localparam int unsigned PIC_DATA_W = 8;
    localparam logic [7:0] PIC_OFS_CLR0 = 8'hDA;
    localparam logic [7:0] PIC_OFS_CLR1 = 8'hDB;
    localparam logic [7:0] PIC_OFS_MSK1 = 8'hDF;
    localparam logic [7:0] PIC_OFS_MSK0 = 8'hE0;
    localparam logic [7:0] PIC_OFS_SWEN = 8'hE1;
    localparam logic [7:0] PIC_OFS_VC = 8'hE2;
    localparam logic [7:0] PIC_OFS_EVST = 8'hF0;
    localparam logic [7:0] PIC_OFS_EVMSK = 8'hF1;
    localparam int unsigned PIC_NSRC = 10;
    localparam int unsigned PIC_CLR1_W = 2;
    localparam int unsigned PIC_SWEN_BIT = 0;
    localparam logic [9:0] PIC_POSTED_RST = 10'h000;
    localparam logic [9:0] PIC_MASK_RST = 10'h000;
    localparam logic PIC_SWEN_RST = 1'b0;
    localparam logic [7:0] PIC_VEC_BASE = 8'h04;
    localparam logic [7:0] PIC_VEC_STEP = 8'h04;
    localparam logic [7:0] PIC_VEC_NONE = 8'h00;
    localparam int unsigned PIC_EV_W = 2;
    localparam int unsigned PIC_EV_PEND = 0;
    localparam int unsigned PIC_EV_VCLR = 1;
    localparam logic [1:0] PIC_EV_RST = 2'h0;
    typedef struct packed {
        logic i2c;
        logic sleep;
        logic spi;
        logic gpio;
        logic timer_zero_source;
        logic cap_touch_source;
        logic analog;
        logic vmon;
    } pic_src0_t;
    typedef struct packed {
        logic timer_two_source;
        logic timer_one_source;
    } pic_src1_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pic_bus_t;
endpackage : pic_pkg

// file: pic_ctrl.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - read clear register returns posted bits
// - write 0, post disabled clears posting
// - clearing absent posting changes nothing
// - write 1, post enabled posts request
// - write 1, post disabled: no change
// - write 0, post enabled: no change
// - clear0 bits 7..0 map eight sources
// - clear1 bit1 timer two, bit0 timer one
// - masked source still records posting
// - mask gates only promotion to pending
// - post enable bit 0, reset zero
// - vector clear write drops all pending, and all posting except a coincident hardware event
// - vector clear read gives top vector
// - mask layout matches clear, 1 unmasks
module pic_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire pic_pkg::pic_bus_t bus_i,
    input wire pic_pkg::pic_src0_t src0_i,
    input wire pic_pkg::pic_src1_t src1_i,
    output logic [7:0] rdata_o,
    output logic [9:0] pending_o,
    output logic irq_o
);
    import pic_pkg::*;

    logic [9:0] posted_q;
    logic [9:0] posted_d;
    logic [9:0] mask_q;
    logic sw_post_enable_q;
    logic [1:0] ev_stat_q;
    logic [1:0] ev_mask_q;
    logic [1:0] ev_set;
    logic [7:0] rdata_q;
    logic [9:0] pending_q;
    logic irq_q;
    logic [9:0] hw_src;
    logic [9:0] wsel;
    logic [9:0] wbits;
    logic [9:0] pend_now;
    logic [7:0] vec_now;
    logic wr_clr0;
    logic wr_clr1;
    logic wr_vc;
    logic rd_evst;

    // timers one and two in bits 9:8, register 0 sources (timer zero included) in 7:0
    assign hw_src = {src1_i, src0_i};
    assign wr_clr0 = bus_i.wr && (bus_i.addr == PIC_OFS_CLR0);
    assign wr_clr1 = bus_i.wr && (bus_i.addr == PIC_OFS_CLR1);
    assign wr_vc = bus_i.wr && (bus_i.addr == PIC_OFS_VC);
    assign rd_evst = bus_i.rd && (bus_i.addr == PIC_OFS_EVST);
    assign wsel = {{2{wr_clr1}}, {8{wr_clr0}}};
    assign wbits = {bus_i.wdata[1:0], bus_i.wdata};
    assign pend_now = posted_q & mask_q;

    always_comb begin
        posted_d = posted_q;
        if (sw_post_enable_q) begin
            posted_d = posted_q | (wsel & wbits);
        end else begin
            posted_d = posted_q & ~(wsel & ~wbits);
        end
        if (wr_vc) begin
            posted_d = '0;
        end
        // hardware last so a coincident event survives the clear
        posted_d = posted_d | hw_src;
    end

    // lowest bit wins: supply monitor is highest priority
    always_comb begin
        vec_now = PIC_VEC_NONE;
        for (int i = PIC_NSRC - 1; i >= 0; i--) begin
            if (pend_now[i]) begin
                vec_now = PIC_VEC_BASE + 8'(i) * PIC_VEC_STEP;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            posted_q <= PIC_POSTED_RST;
        end else if (clk_en_i) begin
            posted_q <= posted_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= PIC_MASK_RST;
            sw_post_enable_q <= PIC_SWEN_RST;
            ev_mask_q <= PIC_EV_RST;
        end else if (clk_en_i && bus_i.wr) begin
            // reserved bits dropped; software should write them zero
            case (bus_i.addr)
                PIC_OFS_MSK0: mask_q[7:0] <= bus_i.wdata;
                PIC_OFS_MSK1: mask_q[9:8] <= bus_i.wdata[1:0];
                PIC_OFS_SWEN: sw_post_enable_q <= bus_i.wdata[PIC_SWEN_BIT];
                PIC_OFS_EVMSK: ev_mask_q <= bus_i.wdata[1:0];
                default: ;
            endcase
        end
    end

    // events: new pending promotion and vector clear
    assign ev_set[PIC_EV_PEND] = |(pend_now & ~pending_q);
    assign ev_set[PIC_EV_VCLR] = wr_vc;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ev_stat_q <= PIC_EV_RST;
        end else if (clk_en_i) begin
            // set wins over the read clear
            ev_stat_q <= (rd_evst ? 2'h0 : ev_stat_q) | ev_set;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pending_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            pending_q <= wr_vc ? 10'h000 : pend_now;
            irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (clk_en_i) begin
            rdata_q <= 8'h00;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    PIC_OFS_CLR0: rdata_q <= posted_q[7:0];
                    PIC_OFS_CLR1: rdata_q <= {6'h00, posted_q[9:8]};
                    PIC_OFS_MSK0: rdata_q <= mask_q[7:0];
                    PIC_OFS_MSK1: rdata_q <= {6'h00, mask_q[9:8]};
                    PIC_OFS_SWEN: rdata_q <= {7'h00, sw_post_enable_q};
                    PIC_OFS_VC: rdata_q <= vec_now;
                    PIC_OFS_EVST: rdata_q <= {6'h00, ev_stat_q};
                    PIC_OFS_EVMSK: rdata_q <= {6'h00, ev_mask_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;
    assign pending_o = pending_q;
    assign irq_o = irq_q;

    property p_clear_zero;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && wr_clr0 && !sw_post_enable_q && !bus_i.wdata[0] && !hw_src[0]
            && !wr_vc) |=> !posted_q[0];
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear write kept posting");

    property p_sw_post;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && wr_clr1 && sw_post_enable_q && bus_i.wdata[1] && !wr_vc)
            |=> posted_q[9];
    endproperty
    a_sw_post: assert property (p_sw_post) else $error("software post missed");

    property p_one_noeffect;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && wr_clr0 && !sw_post_enable_q && bus_i.wdata[3])
            |=> posted_q[3] == $past(posted_q[3]) || $past(hw_src[3]);
    endproperty
    a_one_noeffect: assert property (p_one_noeffect) else $error("write one changed state");

    // any soft-post write, so every zero bit of it is covered
    sequence s_soft_write;
        clk_en_i && sw_post_enable_q && (wr_clr0 || wr_clr1);
    endsequence
    property p_zero_noeffect;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_soft_write |=> (posted_q & $past(posted_q)) == $past(posted_q);
    endproperty
    a_zero_noeffect: assert property (p_zero_noeffect) else $error("soft post cleared");

    property p_hw_wins;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && hw_src[7]) |=> posted_q[7];
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("hardware event lost");

    property p_mask_gate;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !mask_q[2]) |=> !pending_q[2];
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked source pending");

    sequence s_vc_write;
        clk_en_i && wr_vc && hw_src == 10'h000;
    endsequence
    property p_vc_clear;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_vc_write |=> posted_q == 10'h000 && pending_q == 10'h000;
    endproperty
    a_vc_clear: assert property (p_vc_clear) else $error("vector clear incomplete");

    property p_read_posted;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && bus_i.rd && bus_i.addr == PIC_OFS_CLR0)
            |=> rdata_o == $past(posted_q[7:0]);
    endproperty
    a_read_posted: assert property (p_read_posted) else $error("posted read wrong");

    sequence s_empty_clear;
        clk_en_i && !sw_post_enable_q && (wr_clr0 || wr_clr1)
            && (wsel & ~wbits & posted_q) == 10'h000 && hw_src == 10'h000;
    endsequence
    property p_clear_keep;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_empty_clear |=> $stable(posted_q);
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("empty clear moved");

    property p_map_vmon;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && src0_i.vmon) |=> posted_q[0];
    endproperty
    a_map_vmon: assert property (p_map_vmon) else $error("monitor off bit 0");

    property p_map_timer_two;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && src1_i.timer_two_source) |=> posted_q[9];
    endproperty
    a_map_timer_two: assert property (p_map_timer_two) else $error("timer two lost");

    property p_read_clr1;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && bus_i.rd && bus_i.addr == PIC_OFS_CLR1)
            |=> rdata_o == {6'h00, $past(posted_q[9:8])};
    endproperty
    a_read_clr1: assert property (p_read_clr1) else $error("clear1 read wrong");

    property p_swen_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && bus_i.wr && bus_i.addr == PIC_OFS_SWEN)
            |=> sw_post_enable_q == $past(bus_i.wdata[PIC_SWEN_BIT]);
    endproperty
    a_swen_write: assert property (p_swen_write) else $error("post enable lost");

    property p_mask0_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && bus_i.wr && bus_i.addr == PIC_OFS_MSK0)
            |=> mask_q[7:0] == $past(bus_i.wdata);
    endproperty
    a_mask0_write: assert property (p_mask0_write) else $error("mask0 write lost");

    property p_mask1_write;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && bus_i.wr && bus_i.addr == PIC_OFS_MSK1)
            |=> mask_q[9:8] == $past(bus_i.wdata[1:0]);
    endproperty
    a_mask1_write: assert property (p_mask1_write) else $error("mask1 write lost");

    property p_pend_follow;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !wr_vc) |=> pending_q == $past(posted_q & mask_q);
    endproperty
    a_pend_follow: assert property (p_pend_follow) else $error("pending wrong");

    sequence s_vec_read;
        clk_en_i && bus_i.rd && bus_i.addr == PIC_OFS_VC;
    endsequence
    property p_vec_top;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_vec_read ##0 (pend_now[1:0] == 2'b10)
            |=> rdata_o == PIC_VEC_BASE + PIC_VEC_STEP;
    endproperty
    a_vec_top: assert property (p_vec_top) else $error("vector not top");

    property p_vec_none;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_vec_read ##0 (pend_now == 10'h000)
            |=> rdata_o == PIC_VEC_NONE;
    endproperty
    a_vec_none: assert property (p_vec_none) else $error("idle vector wrong");

    property p_ev_pend;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && (pend_now & ~pending_q) != 10'h000) |=> ev_stat_q[PIC_EV_PEND];
    endproperty
    a_ev_pend: assert property (p_ev_pend) else $error("promotion event lost");

    property p_ev_rd_clear;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && rd_evst && ev_set == 2'h0) |=> ev_stat_q == 2'h0;
    endproperty
    a_ev_rd_clear: assert property (p_ev_rd_clear) else $error("status read kept bits");

    property p_irq_level;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i |=> irq_o == $past(|(ev_stat_q & ev_mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    // enable low must hold posting, mask, read data and irq
    property p_freeze;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !clk_en_i
            |=> $stable(posted_q) && $stable(mask_q) && $stable(rdata_o) && $stable(irq_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_reset_rel;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> posted_q == PIC_POSTED_RST && mask_q == PIC_MASK_RST
            && sw_post_enable_q == PIC_SWEN_RST && pending_o == 10'h000 && irq_o == 1'b0;
    endproperty
    a_reset_rel: assert property (p_reset_rel) else $error("reset state wrong");

    property p_rdata_idle;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !bus_i.rd) |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
endmodule : pic_ctrl

// file: pic_core_model.sv
`timescale 1ns/1ps
module pic_core_model (
    input wire logic core_clk_i,
    input wire logic [7:0] rdata_i,
    output pic_pkg::pic_bus_t bus_o
);
    import pic_pkg::*;
    initial bus_o = '0;
    // strobe dropped after one cycle, so calls are never back to back
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge core_clk_i);
        bus_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk_i);
        bus_o <= '0;
        #1 q = rdata_i;
    endtask : acc
endmodule : pic_core_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import pic_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en = 1'b1;
    pic_bus_t bus;
    pic_src0_t src0 = '0;
    pic_src1_t src1 = '0;
    logic [7:0] rdata;
    logic [9:0] pending;
    logic irq;
    logic [7:0] rv;
    logic [7:0] regs [9] = '{8'hDA, 8'hDB, 8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hF0, 8'hF1, 8'h10};
    int num_errors = 0;
    int n_tests = 0;
    always #5 core_clk_i = ~core_clk_i;
    pic_ctrl pic_ctrl_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
        .bus_i(bus), .src0_i(src0), .src1_i(src1), .rdata_o(rdata),
        .pending_o(pending), .irq_o(irq));
    pic_core_model pic_core_model_i (.core_clk_i(core_clk_i), .rdata_i(rdata), .bus_o(bus));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pic_core_model_i.acc(1'b1, a, d, rv);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        pic_core_model_i.acc(1'b0, a, 8'h00, rv);
        chk({2'h0, rv}, {2'h0, exp});
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : idle
    task automatic t_reset;
        // last entry is unmapped and must read zero
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_hw;
        @(posedge core_clk_i);
        src0 <= 8'hA5;
        src1 <= 2'b10;
        @(posedge core_clk_i);
        src0 <= '0;
        src1 <= '0;
        rd_chk(8'hDA, 8'hA5);
        rd_chk(8'hDB, 8'h02);
        wr(8'hDA, 8'h0F);
        rd_chk(8'hDA, 8'h05);
        wr(8'hDB, 8'h00);
        rd_chk(8'hDB, 8'h00);
        idle(3);
        chk(pending, 10'h000);
        $display("test hw_post done");
    endtask : t_hw
    task automatic t_sw;
        wr(8'hE1, 8'h01);
        wr(8'hDA, 8'h5A);
        wr(8'hDA, 8'h00);
        rd_chk(8'hDA, 8'h5F);
        wr(8'hDB, 8'h03);
        rd_chk(8'hDB, 8'h03);
        rd_chk(8'hE1, 8'h01);
        wr(8'hE1, 8'h00);
        $display("test sw_post done");
    endtask : t_sw
    task automatic t_mask;
        wr(8'hF1, 8'h01);
        rd_chk(8'hF1, 8'h01);
        wr(8'hE0, 8'hFE);
        wr(8'hDF, 8'h03);
        idle(3);
        chk(pending, 10'h35E);
        chk({9'h0, irq}, 10'h001);
        rd_chk(8'hF0, 8'h01);
        idle(2);
        chk({9'h0, irq}, 10'h000);
        rd_chk(8'hE2, 8'h08);
        wr(8'hE2, 8'h00);
        rd_chk(8'hDA, 8'h00);
        rd_chk(8'hDB, 8'h00);
        rd_chk(8'hF0, 8'h02);
        idle(3);
        chk(pending, 10'h000);
        $display("test mask_vector done");
    endtask : t_mask
    task automatic t_race;
        fork
            wr(8'hDA, 8'h00);
            begin
                @(posedge core_clk_i);
                src0 <= 8'h01;
                @(posedge core_clk_i);
                src0 <= '0;
            end
        join
        rd_chk(8'hDA, 8'h01);
        wr(8'hDA, 8'h00);
        wr(8'hDA, 8'h00);
        rd_chk(8'hDA, 8'h00);
        $display("test race done");
    endtask : t_race
    task automatic t_freeze;
        @(posedge core_clk_i);
        clk_en <= 1'b0;
        src0 <= 8'h80;
        @(posedge core_clk_i);
        src0 <= '0;
        wr(8'hE0, 8'hFF);
        @(posedge core_clk_i);
        clk_en <= 1'b1;
        rd_chk(8'hDA, 8'h00);
        rd_chk(8'hE0, 8'hFE);
        $display("test freeze done");
    endtask : t_freeze
    task automatic end_sim;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_hw();
        t_sw();
        t_mask();
        t_race();
        t_freeze();
        end_sim();
    end
endmodule : testbench
